// File: rtl/fault_supervisor_defines.svh
// Offsets, reset values, field positions and timing counts of the supervisor.
`ifndef FAULT_SUPERVISOR_DEFINES_SVH
`define FAULT_SUPERVISOR_DEFINES_SVH

`define PAGE_COUNT          2
`define CMD_CLEAR_FAULTS    8'h03
`define CMD_UV_THRESHOLD    8'h44
`define CMD_UV_REACTION     8'h45
`define CMD_OC_THRESHOLD    8'h46
`define UV_REACTION_RESET   8'h80
`define OC_THRESHOLD_RESET  16'hDA80
`define UV_THRESHOLD_SCALE  -13
`define UV_STRAP_FACTOR     16'h0D9A
`define UV_STRAP_SHIFT      12
`define REACT_MODE_HI       7
`define REACT_MODE_LO       6
`define REACT_RETRY_HI      5
`define REACT_RETRY_LO      3
`define REACT_MODE_DISABLE  2'b10
`define REACT_RETRY_NONE    3'b000
`define REACT_RETRY_ALWAYS  3'b111
`define LIN_EXP_HI          15
`define LIN_EXP_LO          11
`define LIN_MANT_HI         10
`define LIN_MANT_LO         0
`define AMP_FRAC_BITS       4
`define CLK_FREQ_KHZ        125000
`define UV_RETRY_UNIT_MS    70

`endif

// File: rtl/fault_supervisor_pkg.sv
// Types shared by the fault supervisor and its surroundings.
package fault_supervisor_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        page;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_req_t;

  typedef struct packed {
    logic powerGood;
    logic ramping;
    logic enabledCmd;
    logic biasOk;
    logic otherShutdown;
  } page_state_t;

  typedef struct packed {
    logic               cycleStart;
    logic               strobe;
    logic signed [23:0] amps;
  } current_sample_t;

  typedef enum logic [1:0] {
    OUT_RUN        = 2'b00,
    OUT_LATCHED    = 2'b01,
    OUT_RETRY_WAIT = 2'b10
  } out_state_t;

endpackage : fault_supervisor_pkg

// File: rtl/vout_uv_iout_oc_fault_supervisor.sv
// Output undervoltage and peak overcurrent supervisor for the output pages.
`timescale 1ns/1ps
`include "fault_supervisor_defines.svh"
module vout_uv_iout_oc_fault_supervisor #(
  parameter int unsigned RETRY_CYCLES =
    `UV_RETRY_UNIT_MS * `CLK_FREQ_KHZ
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire fault_supervisor_pkg::cmd_req_t cmd,
  input  wire logic                     writeProtect,
  input  wire logic [15:0]              voutTargetStrap,
  input  wire fault_supervisor_pkg::page_state_t
                                        pageState [`PAGE_COUNT],
  input  wire logic [15:0]              voutSample [`PAGE_COUNT],
  input  wire fault_supervisor_pkg::current_sample_t
                                        ioutSample [`PAGE_COUNT],
  input  wire logic [7:0]               blankCycles,
  input  wire logic [3:0]               consecSamples,
  input  wire logic [`PAGE_COUNT-1:0]   avgOcDetect,
  output logic                          cmdAck,
  output logic                          cmdNack,
  output logic [15:0]                   rdData,
  output logic                          faultAlertLineN,
  output logic [`PAGE_COUNT-1:0]        statusUvFault,
  output logic [`PAGE_COUNT-1:0]        statusOcFault,
  output logic [`PAGE_COUNT-1:0]        ocFaultEvent,
  output logic [`PAGE_COUNT-1:0]        outputDisable
);
  import fault_supervisor_pkg::*;

  localparam int PAGES = `PAGE_COUNT;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage, one set per page.

  logic [15:0]  uvThreshold [PAGES];
  logic [7:0]   uvReaction  [PAGES];
  logic [15:0]  ocThreshold [PAGES];
  logic         strapPending;
  logic [31:0]  strapProduct;
  logic [15:0]  strapThreshold;
  logic         clearFaults;
  logic         cmdMapped;

  // The strap is caught one cycle after reset release, never inside reset.
  // A write in that first cycle is acknowledged but lost under the strap
  // load, so the host waits one more cycle before its first command.
  assign strapProduct   = voutTargetStrap * `UV_STRAP_FACTOR;
  assign strapThreshold = strapProduct[`UV_STRAP_SHIFT +: 16];

  assign clearFaults = cmd.valid && cmd.write &&
                       (cmd.code == `CMD_CLEAR_FAULTS);
  assign cmdMapped   = (cmd.code == `CMD_UV_THRESHOLD) ||
                       (cmd.code == `CMD_UV_REACTION)  ||
                       (cmd.code == `CMD_OC_THRESHOLD);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strapPending <= 1'b1;
    end else begin
      strapPending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int p = 0; p < PAGES; p++) begin
        uvThreshold[p] <= 16'h0000;
        uvReaction[p]  <= `UV_REACTION_RESET;
        ocThreshold[p] <= `OC_THRESHOLD_RESET;
      end
    end else if (strapPending) begin
      for (int p = 0; p < PAGES; p++) begin
        uvThreshold[p] <= strapThreshold;
      end
    end else if (cmd.valid && cmd.write && !writeProtect) begin
      // Writes are taken whole; a protected write changes no register.
      case (cmd.code)
        `CMD_UV_THRESHOLD: begin
          uvThreshold[cmd.page] <= cmd.data;
        end
        `CMD_UV_REACTION: begin
          uvReaction[cmd.page] <= cmd.data[7:0];
        end
        `CMD_OC_THRESHOLD: begin
          ocThreshold[cmd.page] <= cmd.data;
        end
        default: begin
        end
      endcase
    end
  end

  // Each request gets exactly one reply one cycle later; rdData loads with
  // the reply of a read and then holds until the next read.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmdAck  <= 1'b0;
      cmdNack <= 1'b0;
      rdData  <= 16'h0000;
    end else begin
      cmdAck  <= 1'b0;
      cmdNack <= 1'b0;
      if (cmd.valid) begin
        if (clearFaults) begin
          cmdAck <= 1'b1;
        end else if (!cmdMapped) begin
          cmdNack <= 1'b1;
        end else if (cmd.write && writeProtect) begin
          cmdNack <= 1'b1;
        end else begin
          cmdAck <= 1'b1;
        end
        if (!cmd.write) begin
          case (cmd.code)
            `CMD_UV_THRESHOLD: rdData <= uvThreshold[cmd.page];
            `CMD_UV_REACTION:  rdData <= {8'h00, uvReaction[cmd.page]};
            `CMD_OC_THRESHOLD: rdData <= ocThreshold[cmd.page];
            default:           rdData <= 16'h0000;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Undervoltage detection and reaction.

  logic [PAGES-1:0] uvDetect;
  logic [PAGES-1:0] commandedOff;
  out_state_t       outState   [PAGES];
  // Wide enough for a whole 70 ms retry unit at the core clock.
  logic [23:0]      retryCount [PAGES];

  always_comb begin
    for (int p = 0; p < PAGES; p++) begin
      // The threshold word is compared raw: both sides use 2^-13 volts.
      uvDetect[p] = pageState[p].powerGood &&
                    !pageState[p].ramping &&
                    pageState[p].enabledCmd &&
                    !outputDisable[p] &&
                    (voutSample[p] < uvThreshold[p]);
      commandedOff[p] = !pageState[p].enabledCmd ||
                        !pageState[p].biasOk ||
                        pageState[p].otherShutdown;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statusUvFault <= '0;
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        // A new fault in the clearing cycle keeps the bit set.
        if (uvDetect[p]) begin
          statusUvFault[p] <= 1'b1;
        end else if (clearFaults) begin
          statusUvFault[p] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int p = 0; p < PAGES; p++) begin
        outState[p]   <= OUT_RUN;
        retryCount[p] <= 24'h00_0000;
      end
      outputDisable <= '0;
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        case (outState[p])
          OUT_RUN: begin
            outputDisable[p] <= 1'b0;
            // Unused reaction codes only flag the fault and raise alert.
            if (uvDetect[p] &&
                (uvReaction[p][`REACT_MODE_HI:`REACT_MODE_LO] ==
                 `REACT_MODE_DISABLE)) begin
              outputDisable[p] <= 1'b1;
              if (uvReaction[p][`REACT_RETRY_HI:`REACT_RETRY_LO] ==
                  `REACT_RETRY_ALWAYS) begin
                outState[p]   <= OUT_RETRY_WAIT;
                retryCount[p] <= 24'(RETRY_CYCLES - 1);
              end else begin
                outState[p] <= OUT_LATCHED;
              end
            end
          end
          OUT_LATCHED: begin
            outputDisable[p] <= 1'b1;
            if (clearFaults) begin
              outState[p] <= OUT_RUN;
            end
          end
          OUT_RETRY_WAIT: begin
            outputDisable[p] <= 1'b1;
            // A stop request ends retrying and holds the output off.
            if (commandedOff[p]) begin
              outState[p] <= OUT_LATCHED;
            end else if (retryCount[p] == 24'h00_0000) begin
              outState[p] <= OUT_RUN;
            end else begin
              retryCount[p] <= retryCount[p] - 24'h00_0001;
            end
          end
          default: begin
            outState[p] <= OUT_RUN;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peak overcurrent detection on blanked, debounced samples.

  // The limit keeps 32 bits so the largest exponent cannot overflow it.
  logic signed [31:0] ocLimitAmps [PAGES];
  logic [7:0]         blankCount  [PAGES];
  logic [3:0]         runCount    [PAGES];
  logic [PAGES-1:0]   sampleTaken;
  logic [PAGES-1:0]   sampleOver;
  logic [PAGES-1:0]   peakTrip;
  logic [3:0]         runNeeded;

  // A run length of zero is read as one sample.
  assign runNeeded = (consecSamples == 4'h0) ? 4'h1 : consecSamples;

  always_comb begin
    for (int p = 0; p < PAGES; p++) begin
      logic signed [5:0]  shift;
      logic signed [31:0] mant;
      shift = 6'($signed(ocThreshold[p][`LIN_EXP_HI:`LIN_EXP_LO])) +
              $signed(6'(`AMP_FRAC_BITS));
      mant  = 32'($signed(
                ocThreshold[p][`LIN_MANT_HI:`LIN_MANT_LO]));
      // Limit scaled to sixteenths of an ampere, like the samples.
      if (shift >= 0) begin
        ocLimitAmps[p] = mant <<< shift;
      end else begin
        ocLimitAmps[p] = mant >>> (-shift);
      end
      sampleTaken[p] = ioutSample[p].strobe &&
                       (blankCount[p] >= blankCycles);
      // The compare is strict: a sample equal to the limit starts no run.
      sampleOver[p]  = 32'(ioutSample[p].amps) > ocLimitAmps[p];
      peakTrip[p]    = sampleTaken[p] && sampleOver[p] &&
                       ((runCount[p] + 4'h1) >= runNeeded);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int p = 0; p < PAGES; p++) begin
        blankCount[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        // The count restarts with each switching cycle and then saturates.
        if (ioutSample[p].cycleStart) begin
          blankCount[p] <= 8'h00;
        end else if (blankCount[p] != 8'hFF) begin
          blankCount[p] <= blankCount[p] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int p = 0; p < PAGES; p++) begin
        runCount[p] <= 4'h0;
      end
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        // A run ends on the first accepted sample at or below the limit.
        if (sampleTaken[p]) begin
          if (!sampleOver[p] || peakTrip[p]) begin
            runCount[p] <= 4'h0;
          end else begin
            runCount[p] <= runCount[p] + 4'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      statusOcFault <= '0;
      ocFaultEvent  <= '0;
    end else begin
      for (int p = 0; p < PAGES; p++) begin
        ocFaultEvent[p] <= peakTrip[p] || avgOcDetect[p];
        // A new fault in the clearing cycle keeps the bit set.
        if (peakTrip[p] || avgOcDetect[p]) begin
          statusOcFault[p] <= 1'b1;
        end else if (clearFaults) begin
          statusOcFault[p] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert line follows the sticky status bits of every page.
  // The raw detectors feed it too, so alert falls in the same cycle as the
  // status bit that the fault sets.

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultAlertLineN <= 1'b1;
    end else begin
      faultAlertLineN <= !((|statusUvFault) || (|statusOcFault) ||
                           (|uvDetect) || (|peakTrip) ||
                           (|avgOcDetect));
    end
  end

endmodule : vout_uv_iout_oc_fault_supervisor

// File: sim/fault_supervisor_sva.sv
// Port-level checks of the fault supervisor.
`timescale 1ns/1ps
`include "fault_supervisor_defines.svh"
module fault_supervisor_sva (
  input wire logic                                 clk_sys,
  input wire logic                                 rst,
  input wire fault_supervisor_pkg::cmd_req_t        cmd,
  input wire logic                                 writeProtect,
  input wire fault_supervisor_pkg::page_state_t     pageState [`PAGE_COUNT],
  input wire fault_supervisor_pkg::current_sample_t ioutSample [`PAGE_COUNT],
  input wire logic [`PAGE_COUNT-1:0]               avgOcDetect,
  input wire logic                                 cmdAck,
  input wire logic                                 cmdNack,
  input wire logic                                 faultAlertLineN,
  input wire logic [`PAGE_COUNT-1:0]               statusUvFault,
  input wire logic [`PAGE_COUNT-1:0]               statusOcFault,
  input wire logic [`PAGE_COUNT-1:0]               ocFaultEvent
);
  import fault_supervisor_pkg::*;
  wire logic clrCmd = cmd.valid && cmd.write &&
                      cmd.code == `CMD_CLEAR_FAULTS;
  // The comparison counts only with power good, no ramp and output on.
  wire logic uvLive = pageState[0].powerGood && !pageState[0].ramping &&
                      pageState[0].enabledCmd;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  //////////////////////////////////////////
  sequence s_uv_rise;
    !statusUvFault[0] ##1 statusUvFault[0];
  endsequence
  a_ack_pulse: assert property (
    cmd.valid |=> cmdAck ^ cmdNack) else $error("no single reply");
  a_idle_quiet: assert property (
    !cmd.valid |=> !cmdAck && !cmdNack) else $error("stray reply");
  a_protect_nack: assert property (
    cmd.valid && cmd.write && writeProtect && cmd.code inside
    {`CMD_UV_THRESHOLD, `CMD_UV_REACTION, `CMD_OC_THRESHOLD} |=> cmdNack)
    else $error("protected write taken");
  a_uv_masked: assert property (
    s_uv_rise |-> $past(uvLive)) else $error("masked uv flagged");
  a_alert_low: assert property (
    (|statusUvFault) || (|statusOcFault) |-> !faultAlertLineN)
    else $error("fault without alert");
  a_status_sticky: assert property (
    statusUvFault[0] && !clrCmd |=> statusUvFault[0])
    else $error("uv flag lost");
  a_clear_drops: assert property (
    clrCmd && !pageState[0].powerGood && !avgOcDetect[0] &&
    !ioutSample[0].strobe |=> !statusUvFault[0] && !statusOcFault[0])
    else $error("clear ignored");
  a_oc_event: assert property (
    ocFaultEvent[0] |-> statusOcFault[0] && !faultAlertLineN)
    else $error("oc event unflagged");
  a_avg_trip: assert property (
    avgOcDetect[1] |=> statusOcFault[1]) else $error("avg oc missed");
endmodule : fault_supervisor_sva

// File: sim/pmbus_host_model.sv
// Host model that issues decoded bus requests to the supervisor.
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic                     clk_sys,
  output fault_supervisor_pkg::cmd_req_t cmd
);
  import fault_supervisor_pkg::*;
  initial cmd = '0;
  // A request launches after an edge and is taken at the next edge.
  task automatic xfer(input logic w, input logic p, input logic [7:0] c,
                      input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    cmd = '{valid: 1'b1, write: w, page: p, code: c, data: d};
  endtask : xfer
  // Released data is inverted so a stale word can never pass as fresh.
  task automatic idle();
    @(posedge clk_sys);
    #1;
    cmd.valid = 1'b0;
    cmd.data = ~cmd.data;
  endtask : idle
endmodule : pmbus_host_model

// File: sim/vout_uv_iout_oc_fault_supervisor_tb_top.sv
// Self-checking bench for the fault supervisor.
`timescale 1ns/1ps
`include "fault_supervisor_defines.svh"
module vout_uv_iout_oc_fault_supervisor_tb_top;
  import fault_supervisor_pkg::*;
  localparam int RETRY = 20;
  logic            clk_sys, rst, writeProtect, cmdAck, cmdNack;
  logic            faultAlertLineN, ocEv;
  logic [15:0]     voutTargetStrap, rdData, expUv, d;
  logic [7:0]      blankCycles;
  logic [3:0]      consecSamples;
  logic [1:0]      avgOcDetect, statusUvFault, statusOcFault;
  logic [1:0]      ocFaultEvent, outputDisable;
  cmd_req_t        cmd;
  page_state_t     pageState [`PAGE_COUNT];
  logic [15:0]     voutSample [`PAGE_COUNT];
  current_sample_t ioutSample [`PAGE_COUNT];
  logic [18:0]     e;
  logic [18:0]     expQ [$];
  logic [7:0]      reacts [5] = '{8'h80, 8'h88, 8'hC0, 8'h40, 8'h00};
  int              ampSeq [5] = '{170, 170, 160, 170, 161};
  int              miscompares, check_count, cycles, n;

  vout_uv_iout_oc_fault_supervisor #(.RETRY_CYCLES(RETRY))
    vout_uv_iout_oc_fault_supervisor_inst (.clk_sys, .rst, .cmd,
    .writeProtect, .voutTargetStrap, .pageState, .voutSample, .ioutSample,
    .blankCycles, .consecSamples, .avgOcDetect, .cmdAck, .cmdNack,
    .rdData, .faultAlertLineN, .statusUvFault, .statusOcFault,
    .ocFaultEvent, .outputDisable);
  pmbus_host_model pmbus_host_model_inst (.clk_sys, .cmd);
  //////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chkb(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chkb
  task automatic chkw(input logic [15:0] got, input logic [15:0] exp,
                      input string m);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chkw
  task automatic wr(input logic p, input logic [7:0] c,
                    input logic [15:0] v, input logic ok);
    expQ.push_back({1'b0, ok, !ok, 16'h0000});
    pmbus_host_model_inst.xfer(1'b1, p, c, v);
  endtask : wr
  task automatic rd(input logic p, input logic [7:0] c,
                    input logic [15:0] v, input logic ok);
    expQ.push_back({1'b1, ok, !ok, v});
    pmbus_host_model_inst.xfer(1'b0, p, c, 16'h0000);
  endtask : rd
  task automatic clr();
    wr(1'b0, `CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    wr(1'b1, `CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    pmbus_host_model_inst.idle();
    tick(3);
  endtask : clr
  task automatic done(input string s);
    pmbus_host_model_inst.idle();
    $display("test %s done", s);
  endtask : done
  task automatic oc(input int a, input int dly);
    ioutSample[0].cycleStart = 1'b1;
    tick(1);
    ioutSample[0].cycleStart = 1'b0;
    tick(dly);
    ioutSample[0].amps = 24'(a);
    ioutSample[0].strobe = 1'b1;
    tick(1);
    ocEv = ocFaultEvent[0];
    ioutSample[0].strobe = 1'b0;
    ioutSample[0].amps = ~ioutSample[0].amps;
    tick(1);
  endtask : oc
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  //////////////////////////////////////////
  always @(negedge clk_sys) begin
    if (cmdAck === 1'b1 || cmdNack === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 19'h7_FFFF;
      chkw(16'({cmdAck, cmdNack}), 16'(e[17:16]), "reply");
      if (e[18]) chkw(rdData, e[15:0], "read data");
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h4356));
    rst = 1'b1;
    writeProtect = 1'b0;
    voutTargetStrap = 16'($urandom_range(32'hA000, 32'h2000));
    pageState = '{5'h06, 5'h06};
    voutSample = '{16'h0800, 16'h0800};
    ioutSample = '{'0, '0};
    blankCycles = 8'h04;
    consecSamples = 4'h3;
    avgOcDetect = 2'h0;
    expUv = 16'((32'(voutTargetStrap) * 32'(`UV_STRAP_FACTOR)) >> 12);
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    rd(1'b0, `CMD_UV_REACTION, 16'h0080, 1'b1);
    rd(1'b1, `CMD_OC_THRESHOLD, 16'hDA80, 1'b1);
    rd(1'b1, `CMD_UV_THRESHOLD, expUv, 1'b1);
    rd(1'b0, 8'h7E, 16'h0000, 1'b0);
    done("reset values");
    d = 16'($urandom());
    wr(1'b1, `CMD_OC_THRESHOLD, d, 1'b1);
    wr(1'b0, `CMD_UV_THRESHOLD, 16'h1000, 1'b1);
    rd(1'b1, `CMD_OC_THRESHOLD, d, 1'b1);
    rd(1'b0, `CMD_OC_THRESHOLD, 16'hDA80, 1'b1);
    rd(1'b0, `CMD_UV_THRESHOLD, 16'h1000, 1'b1);
    pmbus_host_model_inst.idle();
    writeProtect = 1'b1;
    wr(1'b0, `CMD_UV_REACTION, 16'h00C0, 1'b0);
    wr(1'b0, `CMD_CLEAR_FAULTS, 16'h0000, 1'b1);
    rd(1'b0, `CMD_UV_REACTION, 16'h0080, 1'b1);
    pmbus_host_model_inst.idle();
    writeProtect = 1'b0;
    done("registers");
    for (int i = 0; i < 5; i++) begin
      wr(1'b0, `CMD_UV_REACTION, {8'h00, reacts[i]}, 1'b1);
      pmbus_host_model_inst.idle();
      pageState[0].powerGood = 1'b1;
      pageState[0].ramping = 1'b1;
      tick(4);
      chkb(statusUvFault[0], 1'b0, "ramp mask");
      pageState[0].ramping = 1'b0;
      pageState[0].enabledCmd = 1'b0;
      tick(4);
      chkb(statusUvFault[0], 1'b0, "off mask");
      pageState[0].enabledCmd = 1'b1;
      tick(3);
      chkb(statusUvFault[0], 1'b1, "uv flag");
      chkb(faultAlertLineN, 1'b0, "alert");
      chkb(outputDisable[0], reacts[i][7:6] == 2'b10, "uv off");
      tick(30);
      chkb(outputDisable[0], reacts[i][7:6] == 2'b10, "held");
      pageState[0].powerGood = 1'b0;
      clr();
      chkb(statusUvFault[0], 1'b0, "flag clear");
      chkb(faultAlertLineN, 1'b1, "alert free");
      chkb(outputDisable[0], 1'b0, "restart");
    end
    done("uv reactions");
    wr(1'b0, `CMD_UV_REACTION, 16'h00B8, 1'b1);
    pmbus_host_model_inst.idle();
    pageState[0].powerGood = 1'b1;
    for (n = 0; n < 9 && outputDisable[0] !== 1'b1; n++)
      tick(1);
    for (n = 0; n < 99 && outputDisable[0] === 1'b1; n++)
      tick(1);
    chkw(16'(n), 16'(RETRY + 1), "retry gap");
    tick(5);
    pageState[0].enabledCmd = 1'b0;
    tick(40);
    chkb(outputDisable[0], 1'b1, "stays off");
    pageState[0] = 5'h06;
    clr();
    chkb(outputDisable[0], 1'b0, "retry clear");
    done("uv retry");
    wr(1'b0, `CMD_OC_THRESHOLD, 16'hF814, 1'b1);
    pmbus_host_model_inst.idle();
    for (int i = 0; i < 3; i++)
      oc(200, 1);
    chkb(statusOcFault[0], 1'b0, "blanked");
    foreach (ampSeq[i])
      oc(ampSeq[i], 10);
    chkb(statusOcFault[0], 1'b0, "short run");
    chkb(ocEv, 1'b0, "no early event");
    oc(161 + int'($urandom_range(40, 0)), 10);
    chkb(ocEv, 1'b1, "oc event");
    chkb(statusOcFault[0], 1'b1, "oc trip");
    tick(1);
    chkb(ocFaultEvent[0], 1'b0, "one pulse");
    avgOcDetect = 2'h2;
    tick(1);
    avgOcDetect = 2'h0;
    tick(1);
    chkb(statusOcFault[1], 1'b1, "avg trip");
    clr();
    chkb(|statusOcFault, 1'b0, "oc clear");
    chkb(faultAlertLineN, 1'b1, "alert free");
    done("overcurrent");
    wr(1'b1, `CMD_UV_REACTION, 16'h00B8, 1'b1);
    pmbus_host_model_inst.idle();
    pageState[0].powerGood = 1'b1;
    tick(3);
    chkb(outputDisable[0], 1'b1, "trip before reset");
    rst = 1'b1;
    pageState[0].powerGood = 1'b0;
    tick(2);
    chkb(statusUvFault[0] | outputDisable[0], 1'b0, "reset state");
    chkb(faultAlertLineN, 1'b1, "reset alert");
    chkw(rdData, 16'h0000, "reset read data");
    tick(1);
    rst = 1'b0;
    rd(1'b0, `CMD_UV_REACTION, 16'h0080, 1'b1);
    rd(1'b1, `CMD_UV_REACTION, 16'h0080, 1'b1);
    rd(1'b0, `CMD_OC_THRESHOLD, 16'hDA80, 1'b1);
    rd(1'b0, `CMD_UV_THRESHOLD, expUv, 1'b1);
    done("second reset");
    tick(3);
    chkw(16'(expQ.size()), 16'h0000, "replies");
    finish_test();
  end
endmodule : vout_uv_iout_oc_fault_supervisor_tb_top

bind vout_uv_iout_oc_fault_supervisor fault_supervisor_sva
  fault_supervisor_sva_inst (.clk_sys, .rst, .cmd, .writeProtect,
  .pageState, .ioutSample, .avgOcDetect, .cmdAck, .cmdNack,
  .faultAlertLineN, .statusUvFault, .statusOcFault, .ocFaultEvent);
